/* ilau_pkg.sv */
// Purpose: Constants and types for the integer logic/arithmetic execution unit
// Assumes: One instruction request per scan step, operands already fetched
// Notes:   Operation
// Operation
// - Remainder op writes only the division remainder
// - Double form: low register, then next high
// - Increment adds one to destination in place
// - Decrement subtracts one from destination in place
// - Pulse variant runs once per condition activation
// - Logic ops are 16 or 32 bits wide
// - AND bit is one only when both one
// - OR bit is zero only when both zero
// - XOR bit is one when bits differ
// - Negate inverts bits, adds one, writes back
// - Remainder operands and result are signed
// - Zero divisor raises error, no result
package ilau_pkg;
   localparam int          HALF_W     = 16;
   localparam int          FULL_W     = 32;
   localparam int          OP_W       = 3;
   localparam int          KIND_W     = 3;
   localparam logic [31:0] ONE_32     = 32'h0000_0001;
   localparam logic [31:0] ZERO_32    = 32'h0000_0000;
   localparam logic [15:0] HALF_MASK  = 16'hffff;

   typedef enum logic [2:0] {
      remainder_op             = 3'h0,
      increment_op             = 3'h1,
      decrement_op             = 3'h2,
      and_op                   = 3'h3,
      or_op                    = 3'h4,
      xor_op                   = 3'h5,
      twos_complement_negate_op = 3'h6
   } opcode_e;

   // Operand kinds: only the numeric register kinds may be written
   typedef enum logic [2:0] {
      kind_const = 3'h0,
      kind_timer = 3'h1,
      kind_count = 3'h2,
      kind_index = 3'h3,
      kind_data  = 3'h4,
      kind_bit   = 3'h5
   } kind_e;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_armed = 2'b01,
      st_held  = 2'b11
   } pulse_state_e;
endpackage : ilau_pkg

/* ilau_pulse_gate.sv */
// Purpose: Decides whether an instruction executes in the current scan step
// Assumes: i_scan marks one program scan step of this instruction
// Notes:   Pulse variant fires on the first scan after the condition rises
`timescale 1ns/1ps
module ilau_pulse_gate (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   // Scan control
   input  wire logic i_scan,
   input  wire logic i_entry_condition_input,
   input  wire logic i_pulse,
   // Decision
   output logic      o_fire
);
   import ilau_pkg::*;

   pulse_state_e state_r;
   pulse_state_e state_nxt;

   // Edge memory advances only on scans, so a held condition never refires
   assign state_nxt = !i_entry_condition_input ? st_idle :
                      (state_r == st_idle) ? st_armed : st_held;
   assign o_fire = i_scan && i_entry_condition_input &&
                   (!i_pulse || state_r == st_idle);

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= st_idle;
      end else if (i_scan) begin
         state_r <= state_nxt;
      end
   end

   a_pulse_once: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_scan && i_pulse && i_entry_condition_input && state_r != st_idle) |-> !o_fire)
      else $error("Pulse variant fired twice in one activation");
   a_pulse_off: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !i_entry_condition_input |-> !o_fire)
      else $error("Fired with entry condition false");
endmodule : ilau_pulse_gate

/* integer_logic_arith_unit.sv */
// Purpose: Executes remainder, inc, dec, and/or/xor and negate instructions
// Assumes: Caller supplies register pairs as low and high halves
// Notes:   Result and write strobe are registered; one scan per request
`timescale 1ns/1ps
module integer_logic_arith_unit (
   // Clock and reset
   input  wire logic                         i_clock,
   input  wire logic                         i_rst_b,
   // Instruction request
   input  wire logic                         i_scan,
   input  wire logic                         i_entry_condition_input,
   input  wire logic                         i_pulse,
   input  wire logic                         i_double,
   input  wire ilau_pkg::opcode_e            i_op,
   input  wire ilau_pkg::kind_e              i_dst_kind,
   // Operands, low and high register of each pair
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_src1_lo,
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_src1_hi,
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_src2_lo,
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_src2_hi,
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_dst_lo,
   input  wire logic [ilau_pkg::HALF_W-1:0]  i_dst_hi,
   // Result
   output logic                              o_wr_lo,
   output logic                              o_wr_hi,
   output logic [ilau_pkg::HALF_W-1:0]       o_res_lo,
   output logic [ilau_pkg::HALF_W-1:0]       o_res_hi,
   output logic                              o_div_zero_err,
   output logic                              o_dst_kind_err
);
   import ilau_pkg::*;

   logic                fire;
   logic [FULL_W-1:0]   a_w;
   logic [FULL_W-1:0]   b_w;
   logic [FULL_W-1:0]   d_w;
   logic [FULL_W-1:0]   rem_w;
   logic [FULL_W-1:0]   res_w;
   logic                zero_div;
   logic                dst_ok;
   logic                write_ok;

   ilau_pulse_gate ilau_pulse_gate_inst (
      .i_clock                 (i_clock),
      .i_rst_b                 (i_rst_b),
      .i_scan                  (i_scan),
      .i_entry_condition_input (i_entry_condition_input),
      .i_pulse                 (i_pulse),
      .o_fire                  (fire)
   );

   // Single form sign-extends so the signed remainder sees the true value
   assign a_w = i_double ? {i_src1_hi, i_src1_lo}
                         : {{HALF_W{i_src1_lo[HALF_W-1]}}, i_src1_lo};
   assign b_w = i_double ? {i_src2_hi, i_src2_lo}
                         : {{HALF_W{i_src2_lo[HALF_W-1]}}, i_src2_lo};
   assign d_w = i_double ? {i_dst_hi, i_dst_lo} : {HALF_W'(0), i_dst_lo};

   // Divisor zero check guards the modulo so no garbage result is ever written
   assign zero_div = (b_w == ZERO_32);
   assign rem_w    = zero_div ? ZERO_32 : FULL_W'($signed(a_w) % $signed(b_w));
   assign dst_ok   = (i_dst_kind == kind_timer) || (i_dst_kind == kind_count) ||
                     (i_dst_kind == kind_index) || (i_dst_kind == kind_data);

   always_comb begin
      case (i_op)
         remainder_op:              res_w = rem_w;
         increment_op:              res_w = d_w + ONE_32;
         decrement_op:              res_w = d_w - ONE_32;
         and_op:                    res_w = a_w & b_w;
         or_op:                     res_w = a_w | b_w;
         xor_op:                    res_w = a_w ^ b_w;
         twos_complement_negate_op: res_w = (~d_w) + ONE_32;
         default:                   res_w = ZERO_32;
      endcase
   end

   assign write_ok = fire && dst_ok && !(i_op == remainder_op && zero_div);

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wr_lo        <= 1'b0;
         o_wr_hi        <= 1'b0;
         o_res_lo       <= '0;
         o_res_hi       <= '0;
         o_div_zero_err <= 1'b0;
         o_dst_kind_err <= 1'b0;
      end else begin
         o_wr_lo        <= write_ok;
         o_wr_hi        <= write_ok && i_double;
         o_res_lo       <= res_w[HALF_W-1:0];
         o_res_hi       <= i_double ? res_w[FULL_W-1:HALF_W] : '0;
         o_div_zero_err <= fire && (i_op == remainder_op) && zero_div;
         o_dst_kind_err <= fire && !dst_ok;
      end
   end

   // Named steps shared by the checks below
   sequence s_issue_ok;
      fire && dst_ok;
   endsequence

   sequence s_issue_double;
      fire && dst_ok && i_double;
   endsequence

   sequence s_issue_single;
      fire && dst_ok && !i_double;
   endsequence

   // Logic results, low half and the high half of the pair form
   a_and_bits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_ok ##0 (i_op == and_op)) |=>
      (o_wr_lo && o_res_lo == ($past(i_src1_lo) & $past(i_src2_lo))))
      else $error("AND result wrong");

   a_and_high: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == and_op)) |=>
      (o_wr_hi && o_res_hi == ($past(i_src1_hi) & $past(i_src2_hi))))
      else $error("AND high half wrong");

   a_or_bits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_ok ##0 (i_op == or_op)) |=>
      (o_res_lo == ($past(i_src1_lo) | $past(i_src2_lo))))
      else $error("OR result wrong");

   a_or_high: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == or_op)) |=>
      (o_wr_hi && o_res_hi == ($past(i_src1_hi) | $past(i_src2_hi))))
      else $error("OR high half wrong");

   a_xor_bits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_ok ##0 (i_op == xor_op)) |=>
      (o_res_lo == ($past(i_src1_lo) ^ $past(i_src2_lo))))
      else $error("XOR result wrong");

   a_xor_high: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == xor_op)) |=>
      (o_wr_hi && o_res_hi == ($past(i_src1_hi) ^ $past(i_src2_hi))))
      else $error("XOR high half wrong");

   // In-place arithmetic on the destination
   a_inc_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_single ##0 (i_op == increment_op)) |=>
      (o_res_lo == $past(i_dst_lo) + 16'h0001))
      else $error("Increment result wrong");

   a_inc_pair: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == increment_op)) |=>
      ({o_res_hi, o_res_lo} == {$past(i_dst_hi), $past(i_dst_lo)} + 32'h0000_0001))
      else $error("Pair increment wrong");

   a_dec_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_single ##0 (i_op == decrement_op)) |=>
      (o_res_lo == $past(i_dst_lo) - 16'h0001))
      else $error("Decrement result wrong");

   a_dec_pair: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == decrement_op)) |=>
      ({o_res_hi, o_res_lo} == {$past(i_dst_hi), $past(i_dst_lo)} - 32'h0000_0001))
      else $error("Pair decrement wrong");

   a_neg_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == twos_complement_negate_op)) |=>
      ({o_res_hi, o_res_lo} + {$past(i_dst_hi), $past(i_dst_lo)} == 32'h0000_0000))
      else $error("Negate result wrong");

   a_neg_single: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_single ##0 (i_op == twos_complement_negate_op)) |=>
      (o_res_lo + $past(i_dst_lo) == 16'h0000))
      else $error("Single negate wrong");

   // Signed remainder and its refusal on a zero divisor
   a_rem_single: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_single ##0 (i_op == remainder_op && i_src2_lo != 16'h0000)) |=>
      (o_wr_lo && o_res_lo == 16'($signed($past(i_src1_lo)) % $signed($past(i_src2_lo)))))
      else $error("Remainder result wrong");

   a_rem_sign: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (s_issue_double ##0 (i_op == remainder_op && {i_src2_hi, i_src2_lo} != 32'h0000_0000)) |=>
      (o_res_hi[15] == $past(i_src1_hi[15]) || {o_res_hi, o_res_lo} == 32'h0000_0000))
      else $error("Remainder sign wrong");

   a_div_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (fire && i_op == remainder_op && i_src2_lo == 16'h0000 && !i_double) |=>
      (o_div_zero_err && !o_wr_lo))
      else $error("Zero divisor not flagged");

   a_err_no_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_div_zero_err |->
      (!o_wr_lo && !o_wr_hi))
      else $error("Write despite zero divisor");

   // Write strobes follow only a true scan and a legal destination
   a_no_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !(i_scan && i_entry_condition_input) |=>
      (!o_wr_lo && !o_wr_hi))
      else $error("Write with entry condition false");

   a_wr_cause: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_wr_lo |->
      $past(i_scan && i_entry_condition_input))
      else $error("Write without a true scan");

   a_pair_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_wr_hi |->
      o_wr_lo)
      else $error("High half written alone");

   a_single_hi: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (o_wr_lo && !o_wr_hi) |->
      (o_res_hi == 16'h0000))
      else $error("High half not cleared in single form");

   a_dst_kind: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_dst_kind == kind_const) |=>
      !o_wr_lo)
      else $error("Constant destination written");

   a_kind_err: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (fire && !dst_ok) |=>
      (o_dst_kind_err && !o_wr_lo))
      else $error("Bad destination not flagged");
endmodule : integer_logic_arith_unit

/* integer_logic_arith_unit_bench.sv */
// Purpose: Self-checking bench for the integer logic and arithmetic unit
// Assumes: One scan request every two clocks, answer one clock later
// Notes:   Logic patterns reuse one word pair in both widths
`timescale 1ns/1ps
module integer_logic_arith_unit_bench;
   import ilau_pkg::*;
   logic        i_clock, i_rst_b, i_scan, i_entry_condition_input, i_pulse, i_double;
   opcode_e     i_op;
   kind_e       i_dst_kind;
   logic [15:0] i_src1_lo, i_src1_hi, i_src2_lo, i_src2_hi, i_dst_lo, i_dst_hi, o_res_lo, o_res_hi;
   logic        o_wr_lo, o_wr_hi, o_div_zero_err, o_dst_kind_err;
   int          n_fail = 0;
   int          compares = 0;
   localparam logic [31:0] A = 32'h366c_f831;
   localparam logic [31:0] B = 32'hf831_366c;
   integer_logic_arith_unit integer_logic_arith_unit_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_scan(i_scan), .i_entry_condition_input(i_entry_condition_input), .i_pulse(i_pulse),
      .i_double(i_double), .i_op(i_op), .i_dst_kind(i_dst_kind), .i_src1_lo(i_src1_lo),
      .i_src1_hi(i_src1_hi), .i_src2_lo(i_src2_lo), .i_src2_hi(i_src2_hi), .i_dst_lo(i_dst_lo),
      .i_dst_hi(i_dst_hi), .o_wr_lo(o_wr_lo), .o_wr_hi(o_wr_hi), .o_res_lo(o_res_lo),
      .o_res_hi(o_res_hi), .o_div_zero_err(o_div_zero_err), .o_dst_kind_err(o_dst_kind_err));
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Flags first; result only counts while a write strobe stands
   task automatic run(input opcode_e op, input logic dbl, pls, cnd, input kind_e k,
                      input logic [31:0] s1, s2, d, output logic [35:0] got);
      @(posedge i_clock);
      #1;
      i_op = op;
      i_dst_kind = k;
      {i_double, i_pulse, i_entry_condition_input, i_scan} = {dbl, pls, cnd, 1'b1};
      {i_src1_hi, i_src1_lo, i_src2_hi, i_src2_lo, i_dst_hi, i_dst_lo} = {s1, s2, d};
      @(posedge i_clock);
      #1;
      i_scan = 1'b0;
      got = {o_div_zero_err, o_dst_kind_err, o_wr_hi, o_wr_lo, o_wr_lo ? {o_res_hi, o_res_lo} : 32'h0};
   endtask : run
   task automatic op_ok(input opcode_e op, input logic dbl, input logic [31:0] s1, s2, d, exp);
      logic [35:0] g;
      run(op, dbl, 1'b0, 1'b1, kind_data, s1, s2, d, g);
      chk(g, {2'b00, dbl, 1'b1, exp});
   endtask : op_ok
   task automatic t_logic;
      opcode_e     ops[3] = '{and_op, or_op, xor_op};
      logic [15:0] r[3] = '{16'h3020, 16'hfe7d, 16'hce5d};
      for (int i = 0; i < 3; i++) begin
         op_ok(ops[i], 1'b0, A, B, 32'h0, {16'h0, r[i]});
         op_ok(ops[i], 1'b1, A, B, 32'h0, {r[i], r[i]});
      end
      $display("logic ops done");
   endtask : t_logic
   task automatic t_arith;
      logic [35:0] g;
      op_ok(increment_op, 1'b0, 0, 0, 32'h1234_ffff, 32'h0);
      op_ok(increment_op, 1'b1, 0, 0, 32'h0000_ffff, 32'h0001_0000);
      op_ok(decrement_op, 1'b0, 0, 0, 32'h0, 32'h0000_ffff);
      op_ok(decrement_op, 1'b1, 0, 0, 32'h0001_0000, 32'h0000_ffff);
      op_ok(twos_complement_negate_op, 1'b0, 0, 0, 32'h5, 32'h0000_fffb);
      op_ok(twos_complement_negate_op, 1'b1, 0, 0, 32'h1, 32'hffff_ffff);
      op_ok(remainder_op, 1'b0, 32'h0000_fff9, 32'h3, 0, 32'h0000_ffff);
      op_ok(remainder_op, 1'b1, 32'hffff_fff9, 32'h3, 0, 32'hffff_ffff);
      op_ok(remainder_op, 1'b1, 32'h7, 32'hffff_fffd, 0, 32'h1);
      op_ok(remainder_op, 1'b1, 32'h0001_0005, 32'h0001_0000, 0, 32'h5);
      run(remainder_op, 1'b1, 1'b0, 1'b1, kind_data, 32'h9, 32'h0, 0, g);
      chk(g, {4'b1000, 32'h0});
      // Single form ignores the high register, so the divisor is zero here
      run(remainder_op, 1'b0, 1'b0, 1'b1, kind_data, 32'h9, 32'h0001_0000, 0, g);
      chk(g, {4'b1000, 32'h0});
      $display("arith ops done");
   endtask : t_arith
   task automatic t_gate;
      logic [35:0] g;
      kind_e       ks[6] = '{kind_const, kind_timer, kind_count, kind_index, kind_data, kind_bit};
      run(increment_op, 1'b1, 1'b0, 1'b0, kind_data, 0, 0, 32'h7, g);
      chk(g, 36'h0);
      for (int i = 0; i < 6; i++) begin
         run(increment_op, 1'b0, 1'b0, 1'b1, ks[i], 0, 0, 32'h7, g);
         chk(g, (i == 0 || i == 5) ? {4'b0100, 32'h0} : {4'b0001, 32'h8});
      end
      $display("gate checks done");
   endtask : t_gate
   task automatic t_pulse;
      logic [35:0] g;
      logic [5:0]  cnd = 6'b10_1110;
      logic [5:0]  wr = 6'b10_0010;
      for (int i = 0; i < 6; i++) begin
         run(increment_op, 1'b0, 1'b1, cnd[i], kind_data, 0, 0, 32'h0, g);
         chk(g, wr[i] ? {4'b0001, 32'h1} : 36'h0);
      end
      $display("pulse checks done");
   endtask : t_pulse
   task automatic close_out;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   initial begin
      {i_rst_b, i_scan, i_entry_condition_input, i_pulse, i_double} = 5'h0;
      i_op = and_op;
      i_dst_kind = kind_data;
      {i_src1_hi, i_src1_lo, i_src2_hi, i_src2_lo, i_dst_hi, i_dst_lo} = 96'h0;
      repeat (10) @(posedge i_clock);
      #1;
      i_rst_b = 1'b1;
      t_logic();
      t_arith();
      t_gate();
      t_pulse();
      close_out();
   end
   // Thirty-one requests of two clocks each; generous margin
   initial begin
      #40000;
      n_fail++;
      close_out();
   end
endmodule : integer_logic_arith_unit_bench
